// ==== design/home_return_pkg.sv ====
// types shared by the homing sequencer and its bench
// assumes the _regs header carries offsets, fields and reset values; method and state codes live here
package home_return_pkg;

  typedef enum logic [3:0] {
    M_DOG         = 4'h0,
    M_COUNT       = 4'h1,
    M_DATA_SET    = 4'h2,
    M_STOPPER     = 4'h3,
    M_IGNORE      = 4'h4,
    M_REAR_REF    = 4'h5,
    M_COUNT_FRONT = 4'h6,
    M_CRADLE      = 4'h7,
    M_LAST_INDEX  = 4'h8,
    M_FRONT_REF   = 4'h9,
    M_DOGLESS     = 4'hA
  } method_t;

  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_RETRACT  = 4'h1,
    S_SEEK     = 4'h2,
    S_CREEP    = 4'h3,
    S_TRAVEL   = 4'h4,
    S_INDEX    = 4'h5,
    S_SHIFT    = 4'h6,
    S_STOPPER  = 4'h7,
    S_WAIT_SON = 4'h8,
    S_BACKOFF  = 4'h9,
    S_DONE     = 4'hA
  } state_t;

  // motion request to the speed generator
  typedef struct packed {
    logic move;
    logic fast;
    logic dir_dec;
  } motion_t;

endpackage

// ==== design/home_return_sequencer.sv ====
// homing sequencer: picks the home point from sensor, index and position
// assumes inputs synchronous to core_clk_i and a speed generator obeying motion_o
`timescale 1ns/10ps
`include "home_return_sequencer_regs.svh"

module home_return_sequencer #(
  parameter int POS_W = 32
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic sensor_i,
  input wire logic index_i,
  input wire logic [POS_W-1:0] pos_i,
  input wire logic servo_on_i,
  input wire logic stopped_i,
  output home_return_pkg::motion_t motion_o,
  output logic home_done_o,
  output logic cmd_load_o,
  output logic [POS_W-1:0] cmd_pos_o
);
  import home_return_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [31:0] ctrl_q, ctrl_d;
  logic [POS_W-1:0] shift_q, shift_d;
  logic [POS_W-1:0] travel_q, travel_d;
  logic [POS_W-1:0] hdata_q, hdata_d;
  logic [31:0] rdata_d;
  logic start_d, start_q;
  logic [POS_W-1:0] home_pos_q, home_pos_d;
  logic done_q, done_d;
  logic err_q, err_d;
  state_t state_q, state_d;
  method_t method;
  logic dir_dec;
  logic pol;

  assign method = method_t'(ctrl_q[`HRS_CTRL_METHOD_MSB:`HRS_CTRL_METHOD_LSB]);
  assign dir_dec = ctrl_q[`HRS_CTRL_DIR_BIT];
  assign pol = ctrl_q[`HRS_CTRL_POL_BIT];

  always_comb begin
    ctrl_d = ctrl_q;
    shift_d = shift_q;
    travel_d = travel_q;
    hdata_d = hdata_q;
    start_d = 1'b0;
    rdata_d = 32'h0000_0000;
    if (wr_i) begin
      case (addr_i)
        `HRS_OFS_CTRL: begin
          ctrl_d = wdata_i & 32'h0000_003F;
          start_d = wdata_i[`HRS_CTRL_START_BIT];
        end
        `HRS_OFS_SHIFT: shift_d = wdata_i[POS_W-1:0];
        `HRS_OFS_TRAVEL: travel_d = wdata_i[POS_W-1:0];
        `HRS_OFS_HOME_DATA: hdata_d = wdata_i[POS_W-1:0];
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        `HRS_OFS_CTRL: rdata_d = ctrl_q;
        `HRS_OFS_SHIFT: rdata_d = 32'(shift_q);
        `HRS_OFS_TRAVEL: rdata_d = 32'(travel_q);
        `HRS_OFS_HOME_DATA: rdata_d = 32'(hdata_q);
        `HRS_OFS_STATUS: begin
          rdata_d[`HRS_STAT_DONE_BIT] = done_q;
          rdata_d[`HRS_STAT_BUSY_BIT] = (state_q != S_IDLE) && (state_q != S_DONE);
          rdata_d[`HRS_STAT_ERR_BIT] = err_q;
          rdata_d[`HRS_STAT_STATE_MSB:`HRS_STAT_STATE_LSB] = state_q;
        end
        `HRS_OFS_HOME_POS: rdata_d = 32'(home_pos_q);
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= `HRS_RST_CTRL;
      shift_q <= POS_W'(`HRS_RST_SHIFT);
      travel_q <= POS_W'(`HRS_RST_TRAVEL);
      hdata_q <= POS_W'(`HRS_RST_HOME_DATA);
      start_q <= 1'b0;
      rdata_o <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      shift_q <= shift_d;
      travel_q <= travel_d;
      hdata_q <= hdata_d;
      start_q <= start_d;
      rdata_o <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  logic det;
  logic det_q;
  logic son_q;
  logic rev_q, rev_d;
  logic [POS_W-1:0] mark_q, mark_d;
  logic [POS_W-1:0] goal_q, goal_d;
  logic [POS_W-1:0] moved;
  logic reached;
  logic front_edge;
  logic rear_edge;
  logic son_rise;
  logic finish;
  motion_t motion_d;
  logic load_d;

  assign det = pol ? sensor_i : ~sensor_i;
  assign front_edge = det & ~det_q;
  assign rear_edge = ~det & det_q;
  assign son_rise = servo_on_i & ~son_q;
  // distance covered since mark, measured along the current travel direction
  assign moved = (dir_dec ^ rev_q) ? (mark_q - pos_i) : (pos_i - mark_q);
  assign reached = (moved >= goal_q);

  always_comb begin
    state_d = state_q;
    rev_d = rev_q;
    mark_d = mark_q;
    goal_d = goal_q;
    done_d = done_q;
    err_d = err_q;
    home_pos_d = home_pos_q;
    finish = 1'b0;
    case (state_q)
      S_IDLE, S_DONE: ;
      S_RETRACT: begin
        // back off the sensor the way we came, then seek again
        if (!det) begin
          rev_d = 1'b0;
          state_d = S_SEEK;
        end
      end
      S_SEEK: begin
        if (front_edge || det) begin
          mark_d = pos_i;
          goal_d = travel_q + shift_q;
          case (method)
            M_CRADLE: state_d = S_INDEX;
            M_LAST_INDEX: begin
              rev_d = 1'b1;
              state_d = S_BACKOFF;
            end
            M_COUNT_FRONT, M_FRONT_REF: state_d = S_TRAVEL;
            default: state_d = S_CREEP;
          endcase
        end
      end
      S_CREEP: begin
        if (rear_edge || !det) begin
          mark_d = pos_i;
          case (method)
            M_DOG: state_d = S_INDEX;
            M_COUNT: begin
              goal_d = travel_q;
              state_d = S_TRAVEL;
            end
            default: begin
              goal_d = travel_q + shift_q;
              state_d = S_TRAVEL;
            end
          endcase
        end
      end
      S_BACKOFF: begin
        if (!det) begin
          state_d = S_INDEX;
        end
      end
      S_TRAVEL: begin
        if (reached) begin
          if (method == M_COUNT) begin
            state_d = S_INDEX;
          end else begin
            finish = 1'b1;
          end
        end
      end
      S_INDEX: begin
        if (index_i) begin
          mark_d = pos_i;
          goal_d = shift_q;
          if (method == M_CRADLE) begin
            finish = 1'b1;
          end else begin
            state_d = S_SHIFT;
          end
        end
      end
      S_SHIFT: begin
        if (reached) begin
          finish = 1'b1;
        end
      end
      S_STOPPER: begin
        if (stopped_i) begin
          finish = 1'b1;
        end
      end
      S_WAIT_SON: begin
        if (son_rise) begin
          finish = 1'b1;
        end
      end
      default: state_d = S_IDLE;
    endcase
    if (finish) begin
      home_pos_d = pos_i;
      done_d = 1'b1;
      state_d = S_DONE;
    end
    // a fresh start always wins over whatever is in flight
    if (start_q) begin
      done_d = 1'b0;
      err_d = 1'b0;
      rev_d = 1'b0;
      mark_d = pos_i;
      goal_d = shift_q;
      case (method)
        M_DATA_SET: begin
          home_pos_d = pos_i;
          done_d = 1'b1;
          state_d = S_DONE;
        end
        M_STOPPER: state_d = S_STOPPER;
        M_IGNORE: state_d = S_WAIT_SON;
        M_DOGLESS: state_d = S_INDEX;
        M_DOG, M_COUNT, M_REAR_REF, M_COUNT_FRONT, M_CRADLE, M_LAST_INDEX, M_FRONT_REF: begin
          if (det) begin
            rev_d = 1'b1;
            state_d = S_RETRACT;
          end else begin
            state_d = S_SEEK;
          end
        end
        default: begin
          err_d = 1'b1;
          state_d = S_IDLE;
        end
      endcase
    end
  end

  // motion follows the state being entered so the output stays a flop
  always_comb begin
    motion_d.move = 1'b1;
    motion_d.fast = 1'b0;
    motion_d.dir_dec = dir_dec ^ rev_d;
    load_d = (state_d == S_DONE) && (state_q != S_DONE);
    case (state_d)
      S_RETRACT, S_SEEK: motion_d.fast = 1'b1;
      // stopper runs at creep only; the stop takes the hit
      S_STOPPER: motion_d.fast = 1'b0;
      S_IDLE, S_DONE, S_WAIT_SON: motion_d.move = 1'b0;
      default: ;
    endcase
    // data-set skips straight to done from any state
    if (start_q && (method == M_DATA_SET)) begin
      load_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= S_IDLE;
      rev_q <= 1'b0;
      mark_q <= '0;
      goal_q <= '0;
      det_q <= 1'b0;
      son_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      home_pos_q <= '0;
      motion_o <= '0;
      home_done_o <= 1'b0;
      cmd_load_o <= 1'b0;
      cmd_pos_o <= '0;
    end else begin
      state_q <= state_d;
      rev_q <= rev_d;
      mark_q <= mark_d;
      goal_q <= goal_d;
      det_q <= det;
      son_q <= servo_on_i;
      done_q <= done_d;
      err_q <= err_d;
      home_pos_q <= home_pos_d;
      motion_o <= motion_d;
      home_done_o <= done_d;
      cmd_load_o <= load_d;
      cmd_pos_o <= hdata_q;
    end
  end

endmodule

// ==== design/home_return_sequencer_regs.svh ====
// register offsets, field positions and reset values of the homing sequencer
// assumes a plain 8-bit word-aligned address port with 32-bit data
`ifndef HOME_RETURN_SEQUENCER_REGS_SVH
`define HOME_RETURN_SEQUENCER_REGS_SVH

`define HRS_OFS_CTRL 8'h00
`define HRS_OFS_SHIFT 8'h04
`define HRS_OFS_TRAVEL 8'h08
`define HRS_OFS_HOME_DATA 8'h0C
`define HRS_OFS_STATUS 8'h10
`define HRS_OFS_HOME_POS 8'h14

`define HRS_CTRL_METHOD_LSB 0
`define HRS_CTRL_METHOD_MSB 3
`define HRS_CTRL_DIR_BIT 4
`define HRS_CTRL_POL_BIT 5
`define HRS_CTRL_START_BIT 8

`define HRS_STAT_DONE_BIT 0
`define HRS_STAT_BUSY_BIT 1
`define HRS_STAT_ERR_BIT 2
`define HRS_STAT_STATE_LSB 4
`define HRS_STAT_STATE_MSB 7

`define HRS_RST_CTRL 32'h0000_0000
`define HRS_RST_SHIFT 32'h0000_0000
`define HRS_RST_TRAVEL 32'h0000_0000
`define HRS_RST_HOME_DATA 32'h0000_0000

`endif

// ==== testbench/axis_model.sv ====
// axis model: position, dog sensor, encoder index and stopper
// assumes motion_i registered; dog, index and stopper geometry fixed here
`timescale 1ns/10ps
module axis_model
  import home_return_pkg::*;
#(
  parameter int DOG_LO = 64,
  parameter int DOG_HI = 96,
  parameter int STOP_AT = 200
) (
  input wire logic core_clk_i,
  input wire home_return_pkg::motion_t motion_i,
  input wire logic pol_i,
  input wire logic load_i,
  input wire logic [31:0] load_val_i,
  output logic [31:0] pos_o,
  output logic sensor_o,
  output logic index_o,
  output logic stopped_o
);
  int p = 0;
  int np;
  int off;
  logic jam;
  assign pos_o = p;
  assign sensor_o = (p >= DOG_LO && p < DOG_HI) ~^ pol_i;
  assign jam = p >= STOP_AT && !motion_i.dir_dec;
  ////////////////////////////////////////
  // index fires on crossing, so fast steps cannot skip it
  always @(posedge core_clk_i) begin
    np = p;
    if (motion_i.move && !jam) begin
      np = motion_i.dir_dec ? p - (motion_i.fast ? 4 : 1) : p + (motion_i.fast ? 4 : 1);
    end
    if (load_i) begin
      np = load_val_i;
    end
    off = motion_i.dir_dec ? 17 : 16;
    index_o <= ((np - off) >>> 5) != ((p - off) >>> 5) && !load_i;
    // only a blocked axis reports stop
    stopped_o <= jam;
    p <= np;
  end
endmodule

// ==== testbench/home_return_sequencer_checker.sv ====
// checker: timing relations at the homing sequencer ports
// assumes binding to every home_return_sequencer instance
`timescale 1ns/10ps
`include "home_return_sequencer_regs.svh"
module home_return_sequencer_checker
  import home_return_pkg::*;
#(
  parameter int POS_W = 32
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic sensor_i,
  input wire logic index_i,
  input wire logic [POS_W-1:0] pos_i,
  input wire logic servo_on_i,
  input wire logic stopped_i,
  input wire home_return_pkg::motion_t motion_o,
  input wire logic home_done_o,
  input wire logic cmd_load_o,
  input wire logic [POS_W-1:0] cmd_pos_o
);
  logic [5:0] ctrl_q;
  logic [5:0] ctrl_d;
  logic st_wr;
  logic det;
  logic dog;
  logic fast;
  assign st_wr = wr_i && addr_i == `HRS_OFS_CTRL && wdata_i[`HRS_CTRL_START_BIT];
  // polarity copy: the sensor means nothing without it
  assign det = sensor_i == ctrl_q[5];
  assign dog = ctrl_q[3:0] == M_DOG;
  assign fast = motion_o.move && motion_o.fast;
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_i && addr_i == `HRS_OFS_CTRL) begin
      ctrl_d = wdata_i[5:0];
    end
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= 6'h00;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  AST_DONE_INIT: assert property (!$past(resetn_i) |-> !home_done_o && !cmd_load_o)
    else $error("home flagged right after reset");
  AST_LOAD_DONE: assert property (cmd_load_o |-> home_done_o ##1 !cmd_load_o)
    else $error("load pulse wrong");
  AST_DONE_RISE: assert property ($rose(home_done_o) |-> cmd_load_o && !motion_o.move)
    else $error("done rose without load or with motion");
  AST_DONE_HOLD: assert property ($fell(home_done_o) |-> $past(st_wr, 2) || $past(st_wr, 3))
    else $error("done dropped without restart");
  AST_DATA_SET: assert property (st_wr && wdata_i[3:0] == M_DATA_SET ##1 !st_wr
    |-> ##[1:2] (home_done_o && cmd_load_o)) else $error("data set late");
  AST_SEEK_DIR: assert property (dog && fast && !det && !$past(det)
    |-> motion_o.dir_dec == ctrl_q[4]) else $error("seek direction wrong");
  AST_RETRACT: assert property (dog && fast && det && $past(det)
    |-> motion_o.dir_dec != ctrl_q[4]) else $error("retract direction wrong");
  AST_CREEP: assert property (dog && fast && det && !$past(det) |=> !motion_o.fast)
    else $error("no slowdown at sensor");
endmodule

bind home_return_sequencer home_return_sequencer_checker #(.POS_W(POS_W)) chk (
  .core_clk_i(core_clk_i),
  .resetn_i(resetn_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .sensor_i(sensor_i),
  .index_i(index_i),
  .pos_i(pos_i),
  .servo_on_i(servo_on_i),
  .stopped_i(stopped_i),
  .motion_o(motion_o),
  .home_done_o(home_done_o),
  .cmd_load_o(cmd_load_o),
  .cmd_pos_o(cmd_pos_o)
);

// ==== testbench/test_home_return_sequencer.sv ====
// bench: homing methods against the axis model
// assumes dog 64..95, index at 16 mod 32, stopper at 200
`timescale 1ns/10ps
`include "home_return_sequencer_regs.svh"
module test_home_return_sequencer;
  import home_return_pkg::*;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic servo_on_i = 1'b0;
  logic pol = 1'b1;
  logic ld = 1'b0;
  logic [31:0] ldv = 32'h0;
  logic [31:0] rdata_o;
  logic [31:0] pos_i;
  logic [31:0] cmd_pos_o;
  logic sensor_i;
  logic index_i;
  logic stopped_i;
  logic home_done_o;
  logic cmd_load_o;
  motion_t motion_o;
  int n_mismatch = 0;
  int cmp_count = 0;
  home_return_sequencer dut (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .sensor_i(sensor_i),
    .index_i(index_i),
    .pos_i(pos_i),
    .servo_on_i(servo_on_i),
    .stopped_i(stopped_i),
    .motion_o(motion_o),
    .home_done_o(home_done_o),
    .cmd_load_o(cmd_load_o),
    .cmd_pos_o(cmd_pos_o)
  );
  axis_model mdl (.core_clk_i(core_clk_i), .motion_i(motion_o), .pol_i(pol), .load_i(ld),
    .load_val_i(ldv), .pos_o(pos_i), .sensor_o(sensor_i), .index_o(index_i), .stopped_o(stopped_i));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    logic [31:0] v;
    rd(`HRS_OFS_STATUS, v);
    // sampled off the edge so the flop has settled
    check("done", {31'h0, home_done_o}, 32'h0);
    check("status_done", {31'h0, v[0]}, 32'h0);
    rd(`HRS_OFS_CTRL, v);
    check("ctrl_rst", v, `HRS_RST_CTRL);
    wr(`HRS_OFS_CTRL, 32'hFFFF_FEFF);
    rd(`HRS_OFS_CTRL, v);
    check("ctrl_bits", v, 32'h0000_003F);
    rd(8'h1C, v);
    check("unmapped", v, 32'h0);
  endtask
  // long waits bounded; start pos loaded into the model first
  task automatic t_home(input logic [3:0] m, input logic p, input logic dir, input int start, input int exp);
    logic [31:0] v;
    int i;
    @(posedge core_clk_i);
    ld <= 1'b1;
    ldv <= start;
    pol <= p;
    servo_on_i <= 1'b0;
    wr(`HRS_OFS_CTRL, 32'h100 | {p, dir, m});
    ld <= 1'b0;
    for (i = 0; i < 3000 && cmd_load_o !== 1'b1; i++) begin
      @(posedge core_clk_i);
      if (i == 4) begin
        servo_on_i <= 1'b1;
      end
      #1;
    end
    check("load", {31'h0, cmd_load_o}, 32'h1);
    check("done", {31'h0, home_done_o}, 32'h1);
    check("cmd_pos", cmd_pos_o, 32'h0000_0ABC);
    rd(`HRS_OFS_HOME_POS, v);
    check("home_pos", v, exp);
  endtask
  task automatic t_bad();
    logic [31:0] v;
    wr(`HRS_OFS_CTRL, 32'h0000_010B);
    repeat (4) @(posedge core_clk_i);
    rd(`HRS_OFS_STATUS, v);
    check("bad_err", {31'h0, v[2]}, 32'h1);
    check("bad_done", {31'h0, v[0]}, 32'h0);
  endtask
  ////////////////////////////////////////
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  initial begin
    // about 30k cycles, several times the longest clean run
    #600_000;
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    t_reset();
    wr(`HRS_OFS_SHIFT, 32'h0000_0008);
    wr(`HRS_OFS_TRAVEL, 32'h0000_0014);
    wr(`HRS_OFS_HOME_DATA, 32'h0000_0ABC);
    t_home(M_DOG, 1'b1, 1'b0, 0, 120);
    t_home(M_COUNT, 1'b1, 1'b0, 0, 152);
    t_home(M_DATA_SET, 1'b1, 1'b0, 0, 0);
    t_home(M_STOPPER, 1'b1, 1'b0, 0, 200);
    t_home(M_IGNORE, 1'b1, 1'b0, 0, 0);
    t_home(M_REAR_REF, 1'b1, 1'b0, 0, 124);
    t_home(M_COUNT_FRONT, 1'b1, 1'b0, 0, 92);
    t_home(M_CRADLE, 1'b1, 1'b0, 0, 80);
    t_home(M_LAST_INDEX, 1'b1, 1'b0, 0, 40);
    t_home(M_FRONT_REF, 1'b1, 1'b0, 0, 92);
    t_home(M_DOGLESS, 1'b1, 1'b0, 0, 24);
    t_home(M_DOGLESS, 1'b1, 1'b1, 0, -24);
    t_home(M_DOG, 1'b0, 1'b0, 0, 120);
    t_home(M_DOG, 1'b1, 1'b0, 80, 120);
    t_bad();
    close_out();
  end
endmodule
